// >>> rtl/partner_ability_reg.sv
// partner ability register with management port and interrupt events
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module partner_ability_reg
	import partner_ability_pkg::*;
(
	input  logic        mclk,
	input  logic        rst_b,
	input  logic [4:0]  reg_addr,
	input  logic [15:0] reg_wdata,
	input  logic        reg_wr,
	input  logic        reg_rd,
	output logic [15:0] reg_rdata,
	input  logic        an_enable,
	input  logic        an_restart,
	input  logic        an_complete,
	input  logic        page_rx_valid,
	input  logic [15:0] page_rx_word,
	input  logic        page_rx_is_next,
	input  logic        partner_nway_able,
	input  logic        pd_link_100,
	input  logic        pd_link_10,
	input  logic        link_lost,
	output logic        page_received,
	output logic        irq
);
	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		phase_e      phase;
		logic [15:0] ability;
		logic [15:0] shadow;
		logic        page_received;
		logic        complete_seen;
		logic [15:0] rdata;
	} main_s;

	main_s state_q;
	main_s state_d;

	function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] offs);
		addr_hit = (addr == offs);
	endfunction : addr_hit

	irq_bus_if irq_bus ();

	irq_unit u_irq (
		.mclk  (mclk),
		.rst_b (rst_b),
		.bus   (irq_bus)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode of incoming events

	logic take_base;
	logic take_next;
	logic complete_rise;
	logic pd_ok;
	logic commit;
	logic read_partner;

	// restart outranks every page and detection event of its cycle but the page_received flag, which a page still sets
	assign take_base     = page_rx_valid && !page_rx_is_next && !an_restart;
	assign take_next     = page_rx_valid && page_rx_is_next && !an_restart;
	assign complete_rise = an_complete && !state_q.complete_seen;
	assign pd_ok         = an_enable && !partner_nway_able && !an_restart;
	// a page arriving together with completion is kept, and that completion never commits the shadow
	assign commit        = complete_rise && (state_q.phase == PH_NEXT) && !page_rx_valid
		&& !an_restart;
	assign read_partner  = reg_rd && addr_hit(reg_addr, PARTNER_ABILITY_OFFS);

	assign irq_bus.events[IRQ_BASE_PAGE]    = take_base;
	assign irq_bus.events[IRQ_NEXT_PAGE]    = commit;
	assign irq_bus.events[IRQ_PAR_DETECT]   = pd_ok && (pd_link_100 || pd_link_10);
	assign irq_bus.events[IRQ_REMOTE_FAULT] = take_base && page_rx_word[REMOTE_FAULT_BIT];
	assign irq_bus.wr_status = reg_wr && addr_hit(reg_addr, IRQ_STATUS_OFFS);
	assign irq_bus.wr_mask   = reg_wr && addr_hit(reg_addr, IRQ_MASK_OFFS);
	assign irq_bus.wdata     = reg_wdata[IRQ_WIDTH-1:0];

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		state_d = state_q;
		state_d.complete_seen = an_complete;

		// read data stand for one cycle only, zero otherwise
		state_d.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				PARTNER_ABILITY_OFFS: state_d.rdata = state_q.ability & PARTNER_READ_MASK;
				IRQ_STATUS_OFFS:      state_d.rdata[IRQ_WIDTH-1:0] = irq_bus.status;
				IRQ_MASK_OFFS:        state_d.rdata[IRQ_WIDTH-1:0] = irq_bus.mask;
				default:              state_d.rdata = '0;
			endcase
		end

		if (read_partner || link_lost)
			state_d.page_received = 1'b0;
		if (page_rx_valid)
			state_d.page_received = 1'b1;

		if (an_restart)
		begin
			state_d.ability = PARTNER_RESET;
			state_d.shadow  = PARTNER_RESET;
			state_d.phase   = PH_IDLE;
		end
		else
		begin
			case (state_q.phase)
				PH_IDLE, PH_BASE, PH_NEXT, PH_DONE:
				begin
					// whole base word copied: next page, ack, fault, pause, tech, selector
					if (take_base)
					begin
						state_d.ability = page_rx_word;
						state_d.phase   = PH_BASE;
					end
					else if (take_next)
					begin
						state_d.shadow = page_rx_word;
						state_d.phase  = PH_NEXT;
					end
					else if (commit)
					begin
						state_d.ability = state_q.shadow;
						state_d.phase   = PH_DONE;
					end
					else if (complete_rise)
						state_d.phase = PH_DONE;
				end
				default: state_d.phase = PH_IDLE;
			endcase
			if (pd_ok && pd_link_100)
			begin
				state_d.ability[T100_HALF_BIT] = 1'b1;
				state_d.phase = PH_DONE;
			end
			if (pd_ok && pd_link_10)
			begin
				state_d.ability[T10_HALF_BIT] = 1'b1;
				state_d.phase = PH_DONE;
			end
		end
		// a write to the partner address falls through with no effect
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q.phase         <= PH_IDLE;
			state_q.ability       <= PARTNER_RESET;
			state_q.shadow        <= PARTNER_RESET;
			state_q.page_received <= 1'b0;
			state_q.complete_seen <= 1'b0;
			state_q.rdata         <= 16'h0000;
		end
		else
			state_q <= state_d;
	end

	assign reg_rdata     = state_q.rdata;
	assign page_received = state_q.page_received;
	assign irq           = irq_bus.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic quiet;
	assign quiet = !an_restart && !page_rx_valid && !complete_rise && !pd_ok;

	sequence base_taken_s;
		page_rx_valid && !page_rx_is_next && !an_restart;
	endsequence

	sequence next_buffered_s;
		page_rx_valid && page_rx_is_next && !an_restart;
	endsequence

	sequence commit_s;
		complete_rise && !page_rx_valid && !an_restart && !pd_ok;
	endsequence

	restart_clears_a: assert property (@(posedge mclk) disable iff (!rst_b)
		an_restart |=> (state_q.ability == PARTNER_RESET) && (state_q.phase == PH_IDLE))
		else $error("restart did not clear partner abilities");

	next_page_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s and !pd_ok |=> state_q.ability[NEXT_PAGE_BIT]
			== $past(page_rx_word[NEXT_PAGE_BIT]))
		else $error("next page bit not copied");

	ack_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s |=> state_q.ability[ACK_BIT] == $past(page_rx_word[ACK_BIT]))
		else $error("acknowledge bit not copied");

	fault_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s and page_rx_word[REMOTE_FAULT_BIT]
			|=> state_q.ability[REMOTE_FAULT_BIT] && irq_bus.status[IRQ_REMOTE_FAULT])
		else $error("remote fault not reported");

	pause_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s |=> state_q.ability[PAUSE_BIT] == $past(page_rx_word[PAUSE_BIT]))
		else $error("pause bit not copied");

	tech_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s and !pd_ok
			|=> state_q.ability[TECH_HI:TECH_LO] == $past(page_rx_word[TECH_HI:TECH_LO]))
		else $error("technology bits not copied");

	pd_100_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pd_ok && pd_link_100 |=> state_q.ability[T100_HALF_BIT] && state_q.phase == PH_DONE)
		else $error("parallel detect 100 did not set half duplex bit");

	pd_10_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pd_ok && pd_link_10 |=> state_q.ability[T10_HALF_BIT] && state_q.phase == PH_DONE)
		else $error("parallel detect 10 did not set half duplex bit");

	selector_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s |=> state_q.ability[SELECTOR_HI:SELECTOR_LO]
			== $past(page_rx_word[SELECTOR_HI:SELECTOR_LO]))
		else $error("selector field not copied");

	next_page_commit_a: assert property (@(posedge mclk) disable iff (!rst_b)
		next_buffered_s ##1 (quiet && !an_complete) [*3] ##1 commit_s
			|=> state_q.ability == $past(page_rx_word, 5))
		else $error("next page not committed on completion");

	read_clears_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
		read_partner && !page_rx_valid |=> !page_received)
		else $error("partner read did not clear page received");

	write_ignored_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_wr && addr_hit(reg_addr, PARTNER_ABILITY_OFFS) && quiet
			|=> $stable(state_q.ability))
		else $error("write changed partner register");

	read_window_a: assert property (@(posedge mclk) disable iff (!rst_b)
		read_partner |=> reg_rdata == ($past(state_q.ability) & PARTNER_READ_MASK)
			##1 (reg_rdata == 16'h0000 || $past(reg_rd)))
		else $error("read data wrong or held too long");

	////////////////////////////////////////////////////////////////////////////
	// register bus, flag and event checks

	rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data present without a read");

	reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(reg_rdata & ~PARTNER_READ_MASK) == 16'h0000)
		else $error("reserved partner bits read nonzero");

	status_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_rd && addr_hit(reg_addr, IRQ_STATUS_OFFS)
			|=> reg_rdata == {12'h000, $past(irq_bus.status)})
		else $error("status read data wrong");

	mask_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_rd && addr_hit(reg_addr, IRQ_MASK_OFFS)
			|=> reg_rdata == {12'h000, $past(irq_bus.mask)})
		else $error("mask read data wrong");

	unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_rd && !read_partner && !addr_hit(reg_addr, IRQ_STATUS_OFFS)
			&& !addr_hit(reg_addr, IRQ_MASK_OFFS) |=> reg_rdata == 16'h0000)
		else $error("unmapped address read nonzero");

	flag_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		page_rx_valid |=> page_received)
		else $error("received page not flagged");

	link_lost_clears_a: assert property (@(posedge mclk) disable iff (!rst_b)
		link_lost && !page_rx_valid |=> !page_received)
		else $error("link loss did not clear page received");

	flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!page_rx_valid && !read_partner && !link_lost |=> $stable(page_received))
		else $error("page received changed without cause");

	ability_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		quiet |=> $stable(state_q.ability))
		else $error("partner register changed without an event");

	next_hidden_a: assert property (@(posedge mclk) disable iff (!rst_b)
		next_buffered_s and !pd_ok |=> $stable(state_q.ability))
		else $error("next page shown before completion");

	shadow_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
		an_restart |=> state_q.shadow == PARTNER_RESET)
		else $error("restart left a buffered next page");

	pd_refused_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(!an_enable || partner_nway_able) && !an_restart && !page_rx_valid && !complete_rise
			|=> $stable(state_q.ability))
		else $error("parallel detect counted while not allowed");

	base_event_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s |=> irq_bus.status[IRQ_BASE_PAGE])
		else $error("base page event lost");

	pd_event_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pd_ok && (pd_link_100 || pd_link_10) |=> irq_bus.status[IRQ_PAR_DETECT])
		else $error("parallel detect event lost");

	commit_event_a: assert property (@(posedge mclk) disable iff (!rst_b)
		commit_s and state_q.phase == PH_NEXT
			|=> irq_bus.status[IRQ_NEXT_PAGE] && state_q.phase == PH_DONE)
		else $error("next page commit event lost");

	base_phase_a: assert property (@(posedge mclk) disable iff (!rst_b)
		base_taken_s and !pd_ok |=> state_q.phase == PH_BASE)
		else $error("base page did not move phase");

	next_phase_a: assert property (@(posedge mclk) disable iff (!rst_b)
		next_buffered_s and !pd_ok |=> state_q.phase == PH_NEXT)
		else $error("next page did not move phase");

	lone_complete_a: assert property (@(posedge mclk) disable iff (!rst_b)
		complete_rise && state_q.phase != PH_NEXT && !page_rx_valid && !an_restart && !pd_ok
			|=> $stable(state_q.ability) && state_q.phase == PH_DONE)
		else $error("completion without next page changed register");

	restart_refuse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		an_restart && !irq_bus.status[IRQ_BASE_PAGE]
			|=> !irq_bus.status[IRQ_BASE_PAGE])
		else $error("page taken in a restart cycle");

	mask_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		irq_bus.wr_mask
			|=> irq_bus.mask == $past(reg_wdata[IRQ_WIDTH-1:0]))
		else $error("mask write did not land");

	mask_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!irq_bus.wr_mask |=> $stable(irq_bus.mask))
		else $error("mask changed without a write");

	status_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!irq_bus.wr_status && (irq_bus.events == '0) |=> $stable(irq_bus.status))
		else $error("status changed without event or write");
endmodule : partner_ability_reg

// >>> rtl/partner_ability_pkg.sv
// constants, field layout and types of the partner ability register block
package partner_ability_pkg;
	// register addresses on the management port
	localparam logic [4:0]  PARTNER_ABILITY_OFFS = 5'h05;
	localparam logic [4:0]  IRQ_STATUS_OFFS      = 5'h1a;
	localparam logic [4:0]  IRQ_MASK_OFFS        = 5'h1b;
	// field positions of the partner register
	localparam int          NEXT_PAGE_BIT        = 15;
	localparam int          ACK_BIT              = 14;
	localparam int          REMOTE_FAULT_BIT     = 13;
	localparam int          PAUSE_BIT            = 10;
	localparam int          TECH_HI              = 9;
	localparam int          TECH_LO              = 5;
	localparam int          T100_HALF_BIT        = 7;
	localparam int          T10_HALF_BIT         = 5;
	localparam int          SELECTOR_HI          = 4;
	localparam int          SELECTOR_LO          = 0;
	localparam logic [15:0] PARTNER_RESET        = 16'h0000;
	// bits 12:11 forced low on read
	localparam logic [15:0] PARTNER_READ_MASK    = 16'he7ff;
	// interrupt status layout
	localparam int          IRQ_WIDTH            = 4;
	localparam int          IRQ_BASE_PAGE        = 0;
	localparam int          IRQ_NEXT_PAGE        = 1;
	localparam int          IRQ_PAR_DETECT       = 2;
	localparam int          IRQ_REMOTE_FAULT     = 3;
	localparam logic [3:0]  IRQ_RESET            = 4'h0;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_BASE = 2'b01,
		PH_NEXT = 2'b10,
		PH_DONE = 2'b11
	} phase_e;
endpackage : partner_ability_pkg

// >>> rtl/irq_bus_if.sv
// interface between the register block and its interrupt unit
`timescale 1ns/1ps
interface irq_bus_if;
	import partner_ability_pkg::*;
	logic [IRQ_WIDTH-1:0] events;
	logic                 wr_status;
	logic                 wr_mask;
	logic [IRQ_WIDTH-1:0] wdata;
	logic [IRQ_WIDTH-1:0] status;
	logic [IRQ_WIDTH-1:0] mask;
	logic                 irq;

	modport ctrl (
		output events,
		output wr_status,
		output wr_mask,
		output wdata,
		input  status,
		input  mask,
		input  irq
	);
	modport unit (
		input  events,
		input  wr_status,
		input  wr_mask,
		input  wdata,
		output status,
		output mask,
		output irq
	);
endinterface : irq_bus_if

// >>> rtl/irq_unit.sv
// sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
module irq_unit
	import partner_ability_pkg::*;
(
	input logic     mclk,
	input logic     rst_b,
	irq_bus_if.unit bus
);
	typedef struct packed {
		logic [IRQ_WIDTH-1:0] status;
		logic [IRQ_WIDTH-1:0] mask;
	} irq_s;

	irq_s state_q;
	irq_s state_d;

	always_comb
	begin
		state_d = state_q;
		// set after clear: an event in the clearing cycle survives
		if (bus.wr_status)
			state_d.status = state_q.status & ~bus.wdata;
		state_d.status = state_d.status | bus.events;
		if (bus.wr_mask)
			state_d.mask = bus.wdata;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= '{status: IRQ_RESET, mask: IRQ_RESET};
		else
			state_q <= state_d;
	end

	assign bus.status = state_q.status;
	assign bus.mask   = state_q.mask;
	assign bus.irq    = |(state_q.status & state_q.mask);

	genvar gi;
	generate
		for (gi = 0; gi < IRQ_WIDTH; gi++)
		begin : g_bit
			set_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
				bus.events[gi] |=> bus.status[gi])
				else $error("interrupt event lost");
		end
	endgenerate

	irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
		bus.wr_status && ((bus.status & ~bus.wdata) == '0) && (bus.events == '0)
			|=> !bus.irq)
		else $error("interrupt still high after every status bit cleared");
endmodule : irq_unit

// >>> tb/test_partner_ability_reg.sv
// self-checking bench for the partner ability register block
`timescale 1ns/1ps
module test_partner_ability_reg
	import partner_ability_pkg::*;
;
	`define CHK(nm, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("Error %s expected %h seen %h", nm, exp, got); \
		end \
	end

	logic        mclk;
	logic        rst_b;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        an_enable;
	logic        an_restart;
	logic        an_complete;
	logic        page_rx_valid;
	logic [15:0] page_rx_word;
	logic        page_rx_is_next;
	logic        partner_nway_able;
	logic        pd_link_100;
	logic        pd_link_10;
	logic        link_lost;
	logic        page_received;
	logic        irq;
	int          fail_count;
	int          samples_checked;
	int          cycles;

	partner_ability_reg dut_u (
		.mclk              (mclk),
		.rst_b             (rst_b),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.an_enable         (an_enable),
		.an_restart        (an_restart),
		.an_complete       (an_complete),
		.page_rx_valid     (page_rx_valid),
		.page_rx_word      (page_rx_word),
		.page_rx_is_next   (page_rx_is_next),
		.partner_nway_able (partner_nway_able),
		.pd_link_100       (pd_link_100),
		.pd_link_10        (pd_link_10),
		.link_lost         (link_lost),
		.page_received     (page_received),
		.irq               (irq)
	);

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// whole run is under a hundred cycles; ceiling leaves wide margin
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////
	// read data stands only in the cycle after the strobe edge
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", exp, reg_rdata)
	endtask : rd_chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic page(input logic [15:0] w, input logic nxt);
		@(posedge mclk);
		page_rx_valid   <= 1'b1;
		page_rx_word    <= w;
		page_rx_is_next <= nxt;
		@(posedge mclk);
		page_rx_valid <= 1'b0;
		page_rx_word  <= ~w;
		#1;
	endtask : page

	// 0 restart, 1 pd 100, 2 pd 10, 3 complete, 4 link lost
	task automatic ev(input logic [2:0] k);
		@(posedge mclk);
		an_restart  <= (k == 3'h0);
		pd_link_100 <= (k == 3'h1);
		pd_link_10  <= (k == 3'h2);
		an_complete <= (k == 3'h3);
		link_lost   <= (k == 3'h4);
		@(posedge mclk);
		{an_restart, pd_link_100, pd_link_10, an_complete, link_lost} <= 5'h00;
		#1;
	endtask : ev

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		rst_b = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{an_enable, an_restart, an_complete, page_rx_valid} = 4'h0;
		{page_rx_word, page_rx_is_next, partner_nway_able} = '0;
		{pd_link_100, pd_link_10, link_lost} = 3'h0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		rd_chk(IRQ_STATUS_OFFS, 16'h0000);
		rd_chk(IRQ_MASK_OFFS, 16'h0000);
		`CHK("irq", 1'b0, irq)
		// all ones exercises every field; bits 12:11 read low
		page(16'hffff, 1'b0);
		`CHK("page_received", 1'b1, page_received)
		rd_chk(PARTNER_ABILITY_OFFS, 16'he7ff);
		`CHK("page_received", 1'b0, page_received)
		@(posedge mclk);
		#1;
		`CHK("reg_rdata idle", 16'h0000, reg_rdata)
		wr(PARTNER_ABILITY_OFFS, 16'h0000);
		rd_chk(PARTNER_ABILITY_OFFS, 16'he7ff);
		rd_chk(IRQ_STATUS_OFFS, 16'h0009);
		wr(IRQ_MASK_OFFS, 16'h000f);
		`CHK("irq", 1'b1, irq)
		wr(IRQ_STATUS_OFFS, 16'h0009);
		`CHK("irq", 1'b0, irq)
		rd_chk(IRQ_STATUS_OFFS, 16'h0000);
		rd_chk(5'h1f, 16'h0000);
		ev(3'h0);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		// parallel detect counts only when the partner does not negotiate
		an_enable <= 1'b1;
		partner_nway_able <= 1'b1;
		ev(3'h1);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		partner_nway_able <= 1'b0;
		ev(3'h1);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0080);
		`CHK("irq", 1'b1, irq)
		ev(3'h2);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h00a0);
		rd_chk(IRQ_STATUS_OFFS, 16'h0004);
		wr(IRQ_STATUS_OFFS, 16'h0004);
		ev(3'h0);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		an_enable <= 1'b0;
		ev(3'h1);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		// next page held back until negotiation completes
		page(16'h41e1, 1'b0);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h41e1);
		page(16'h2001, 1'b1);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h41e1);
		ev(3'h3);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h2001);
		rd_chk(IRQ_STATUS_OFFS, 16'h0003);
		page(16'h0001, 1'b0);
		`CHK("page_received", 1'b1, page_received)
		ev(3'h4);
		`CHK("page_received", 1'b0, page_received)
		// completion without a next page keeps the base page
		ev(3'h3);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0001);
		// a page in a restart cycle is refused
		wr(IRQ_STATUS_OFFS, 16'h000f);
		an_restart <= 1'b1;
		page(16'hffff, 1'b0);
		an_restart <= 1'b0;
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		rd_chk(IRQ_STATUS_OFFS, 16'h0000);
		// reset in mid run clears the mask
		rst_b <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK("irq", 1'b0, irq)
		rst_b <= 1'b1;
		rd_chk(IRQ_MASK_OFFS, 16'h0000);
		rd_chk(PARTNER_ABILITY_OFFS, 16'h0000);
		end_of_test();
	end
endmodule : test_partner_ability_reg
